// ### mth_miss_handler.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Processor only looks up; handler writes tags
// - One tag write per cycle, tag or state
// - Every miss except a full match updates tags under handler control
// - Bus is 72 bits; handler fields in 67:0, 71:68 reserved
// - Bus carries handler traffic only during misses
// - Full match: just fetch the sector
// - Synonym mismatch: evict, invalidate, refill same set
// - Tag miss: pick set, evict, invalidate, refill
// - Function at 67:64 changes processor state
// - Four word write enables from address 3:2
// - Streaming cache set at bits 59:58
// - Cache RAM address 21:4 at bits 57:40
// - Tag RAM address 39:5 at bits 39:5
// - Release bus only after all updates
module mth_miss_handler
    import mth_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Transfer bus toward the processor
    input wire logic miss_req,
    input wire logic [TB_W-1:0] tbus_in,
    output logic [TB_W-1:0] tbus_out,
    output logic tbus_oe,
    output logic bus_release,
    // Tag RAM write port
    output logic [TAG_W-1:0] tag_bus_out,
    output logic tag_bus_oe,
    output logic tag_we,
    output logic tag_sel_state,
    output logic [1:0] tag_set
);

    // Whole module state in one record
    typedef struct packed {
        mth_state_t st;
        logic req_s1; // Synchroniser stages for the pins
        logic req_s2;
        logic [TB_W-1:0] tb_s1;
        logic [TB_W-1:0] tb_s2;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic wstrb0;
        logic [1:0] ctrl;
        logic [3:0] cmd; // Captured request fields
        logic [2:0] size;
        logic [2:0] coh;
        logic [1:0] nm;
        logic [1:0] set;
        logic [1:0] state;
        logic [3:0] syn;
        logic [39:0] paddr;
        logic [1:0] fill_set;
        logic [1:0] victim;
        logic [4:0] word_cnt;
        logic [15:0] miss_count;
        logic [TB_W-1:0] tbus_out;
        logic tbus_oe;
        logic bus_release;
        logic [TAG_W-1:0] tag_bus_out;
        logic tag_bus_oe;
        logic tag_we;
        logic tag_sel_state;
        logic [1:0] tag_set;
    } mth_regs_t;

    mth_regs_t q_reg; // Present state
    mth_regs_t q_next; // Next state

    // Next-state logic for bus slave, sequence and pin outputs
    always_comb begin
        q_next = q_reg;
        // Two flops before anything looks at the pins
        q_next.req_s1 = miss_req;
        q_next.req_s2 = q_reg.req_s1;
        q_next.tb_s1 = tbus_in;
        q_next.tb_s2 = q_reg.tb_s1;

        // Write address and data may arrive in either order
        if (s_axi_awvalid && q_reg.awready) begin
            q_next.aw_got = 1'b1;
            q_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q_reg.wready) begin
            q_next.w_got = 1'b1;
            q_next.wdata = s_axi_wdata;
            q_next.wstrb0 = s_axi_wstrb[0];
        end
        if (q_reg.bvalid && s_axi_bready) begin
            q_next.bvalid = 1'b0;
        end
        // Both halves held: perform the write and answer
        if (q_reg.aw_got && q_reg.w_got && !q_reg.bvalid) begin
            q_next.aw_got = 1'b0;
            q_next.w_got = 1'b0;
            q_next.bvalid = 1'b1;
            q_next.bresp = RESP_OKAY;
            if (q_reg.awaddr == ADDR_CTRL) begin
                // Only the low byte holds control bits
                if (q_reg.wstrb0) begin
                    q_next.ctrl = q_reg.wdata[1:0];
                end
            end else if (q_reg.awaddr == ADDR_COUNT) begin
                // A write clears the miss counter unless a miss is taken in the same cycle
                q_next.miss_count = 16'h0000;
            end else if (q_reg.awaddr != ADDR_STATUS && q_reg.awaddr != ADDR_REQ &&
                         q_reg.awaddr != ADDR_PA_LO && q_reg.awaddr != ADDR_PA_HI) begin
                q_next.bresp = RESP_SLVERR;
            end
        end
        // Each channel ready only while its own half is not held and no response is pending, so at most one write is open
        q_next.awready = !q_next.aw_got && !q_next.bvalid;
        q_next.wready = !q_next.w_got && !q_next.bvalid;

        // Read channel: answer one cycle after the address is taken
        if (s_axi_arvalid && q_reg.arready) begin
            q_next.rvalid = 1'b1;
            q_next.rresp = RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CTRL: q_next.rdata = {30'h0000_0000, q_reg.ctrl};
                ADDR_STATUS: q_next.rdata = {25'h000_0000, q_reg.victim, q_reg.fill_set, q_reg.st};
                ADDR_REQ: q_next.rdata = {12'h000, q_reg.cmd, q_reg.size, q_reg.coh, q_reg.nm,
                                          q_reg.set, q_reg.state, q_reg.syn};
                ADDR_PA_LO: q_next.rdata = q_reg.paddr[31:0];
                ADDR_PA_HI: q_next.rdata = {24'h00_0000, q_reg.paddr[39:32]};
                ADDR_COUNT: q_next.rdata = {16'h0000, q_reg.miss_count};
                default: begin
                    // Unmapped reads return zero with an error
                    q_next.rdata = 32'h0000_0000;
                    q_next.rresp = RESP_SLVERR;
                end
            endcase
        end else if (q_reg.rvalid && s_axi_rready) begin
            q_next.rvalid = 1'b0;
        end
        q_next.arready = !q_next.rvalid;

        // Miss handling sequence
        unique case (q_reg.st)
            ST_IDLE: begin
                // Processor hands over the bus; its word is stable while it waits
                if (q_reg.req_s2 && q_reg.ctrl[CTRL_EN]) begin
                    q_next.cmd = q_reg.tb_s2[P_CMD_HI:P_CMD_LO];
                    q_next.size = q_reg.tb_s2[P_SIZE_HI:P_SIZE_LO];
                    q_next.coh = q_reg.tb_s2[P_COH_HI:P_COH_LO];
                    q_next.nm = {q_reg.tb_s2[P_NM_TAG], q_reg.tb_s2[P_NM_SYN]};
                    q_next.set = q_reg.tb_s2[P_SET_HI:P_SET_LO];
                    q_next.state = q_reg.tb_s2[P_ST_HI:P_ST_LO];
                    q_next.syn = q_reg.tb_s2[P_SYN_HI:P_SYN_LO];
                    q_next.paddr = q_reg.tb_s2[P_PA_HI:P_PA_LO];
                    q_next.word_cnt = 5'h00;
                    q_next.miss_count = q_reg.miss_count + 16'h0001;
                    q_next.st = ST_DECODE;
                end
            end
            ST_DECODE: begin
                if (!q_reg.nm[1] && !q_reg.nm[0]) begin
                    // Line already present: only the sector is missing
                    q_next.fill_set = q_reg.set;
                    q_next.st = ST_FILL;
                end else if (!q_reg.nm[1]) begin
                    // Wrong synonym: evict and refill in the same set
                    q_next.fill_set = q_reg.set;
                    q_next.st = ST_INVAL;
                end else begin
                    // Round-robin victim keeps the choice cheap and fair
                    q_next.fill_set = q_reg.victim;
                    q_next.victim = q_reg.victim + 2'h1;
                    q_next.st = ST_INVAL;
                end
            end
            ST_INVAL: q_next.st = ST_TAGWR;
            ST_TAGWR: q_next.st = ST_STWR;
            // Both tag cycles are done; the sector follows
            ST_STWR: q_next.st = ST_FILL;
            ST_FILL: begin
                q_next.word_cnt = q_reg.word_cnt + 5'h01;
                if (q_reg.word_cnt == SECTOR_LAST) begin
                    q_next.st = q_reg.ctrl[CTRL_DRAIN] ? ST_DRAIN : ST_RELEASE;
                end
            end
            // One word lets the processor empty its store queues before release
            ST_DRAIN: q_next.st = ST_RELEASE;
            ST_RELEASE: begin
                // Hold the release until the processor drops its request
                if (!q_reg.req_s2) begin
                    q_next.st = ST_IDLE;
                end
            end
        endcase

        // Pin outputs follow the state being entered, so they line up with it
        q_next.tbus_out = '0; // Reserved bits 71:68 and 4 stay low
        q_next.tbus_oe = (q_next.st != ST_IDLE) && (q_next.st != ST_DECODE) &&
                         (q_next.st != ST_RELEASE);
        q_next.bus_release = (q_next.st == ST_RELEASE);
        q_next.tag_bus_out = '0;
        q_next.tag_bus_oe = 1'b0;
        q_next.tag_we = 1'b0;
        q_next.tag_sel_state = 1'b0;
        q_next.tag_set = q_next.fill_set;
        if (q_next.tbus_oe) begin
            q_next.tbus_out[H_DSET_HI:H_DSET_LO] = q_next.fill_set;
            q_next.tbus_out[H_DADR_HI:H_DADR_LO] = {q_next.paddr[21:7], q_next.word_cnt[4:2]};
            q_next.tbus_out[H_TADR_HI:H_TADR_LO] = q_next.paddr[39:5];
            q_next.tbus_out[H_VSYN_HI:H_VSYN_LO] = q_next.syn;
        end
        unique case (q_next.st)
            ST_INVAL: q_next.tbus_out[H_FN_HI:H_FN_LO] = FN_INVAL;
            ST_TAGWR: begin
                // Tag cycle: all 20 address bits on the tag bus
                q_next.tbus_out[H_FN_HI:H_FN_LO] = FN_TAG_WR;
                q_next.tag_bus_out = q_next.paddr[39:20];
                q_next.tag_bus_oe = 1'b1;
                q_next.tag_we = 1'b1;
            end
            ST_STWR: begin
                // State cycle: state and synonym share the same tag bus
                q_next.tbus_out[H_FN_HI:H_FN_LO] = FN_TAG_ST;
                q_next.tag_bus_out = {14'h0000, q_next.state, q_next.syn};
                q_next.tag_bus_oe = 1'b1;
                q_next.tag_we = 1'b1;
                q_next.tag_sel_state = 1'b1;
            end
            ST_FILL: begin
                q_next.tbus_out[H_FN_HI:H_FN_LO] = FN_FILL;
                q_next.tbus_out[H_WEN_HI:H_WEN_LO] = 4'(WEN_ONE << q_next.word_cnt[1:0]);
            end
            ST_DRAIN: q_next.tbus_out[H_FN_HI:H_FN_LO] = FN_DRAIN;
            ST_IDLE, ST_DECODE, ST_RELEASE: q_next.tbus_out[H_FN_HI:H_FN_LO] = FN_IDLE;
        endcase
    end

    // State register; synchronous reset to constants only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_reg <= '0;
            q_reg.st <= ST_IDLE;
            q_reg.ctrl <= CTRL_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    // Every output straight from the state record
    assign s_axi_awready = q_reg.awready;
    assign s_axi_wready = q_reg.wready;
    assign s_axi_bresp = q_reg.bresp;
    assign s_axi_bvalid = q_reg.bvalid;
    assign s_axi_arready = q_reg.arready;
    assign s_axi_rdata = q_reg.rdata;
    assign s_axi_rresp = q_reg.rresp;
    assign s_axi_rvalid = q_reg.rvalid;
    assign tbus_out = q_reg.tbus_out;
    assign tbus_oe = q_reg.tbus_oe;
    assign bus_release = q_reg.bus_release;
    assign tag_bus_out = q_reg.tag_bus_out;
    assign tag_bus_oe = q_reg.tag_bus_oe;
    assign tag_we = q_reg.tag_we;
    assign tag_sel_state = q_reg.tag_sel_state;
    assign tag_set = q_reg.tag_set;

    // Checks on the driven pins
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Tag RAM cycles: address first, then state and synonym
    chk_tag_write_driven: assert property (tag_we |-> tag_bus_oe && tbus_oe)
        else $error("tag write without driving buses");
    chk_tag_then_state: assert property (tag_we && !tag_sel_state |=> tag_we && tag_sel_state
        && tag_bus_out == {14'h0000, q_reg.state, q_reg.syn})
        else $error("state cycle does not follow tag cycle");
    chk_tag_addr_bits: assert property (tag_we && !tag_sel_state |-> tag_bus_out == q_reg.paddr[39:20])
        else $error("tag cycle address wrong");
    // Each lookup result leads down its own path
    chk_miss_updates_tag: assert property (q_reg.st == ST_DECODE && q_reg.nm[1]
        |=> tbus_out[H_FN_HI:H_FN_LO] == FN_INVAL ##1 tag_we ##1 tag_sel_state)
        else $error("tag miss skipped eviction");
    chk_hit_no_evict: assert property (q_reg.st == ST_DECODE && q_reg.nm == 2'b00
        |=> tbus_out[H_FN_HI:H_FN_LO] == FN_FILL && !tag_we && tag_set == $past(q_reg.set))
        else $error("full match did not go straight to fill");
    chk_syn_same_set: assert property (q_reg.st == ST_DECODE && q_reg.nm == 2'b01
        |=> tbus_out[H_FN_HI:H_FN_LO] == FN_INVAL && tag_set == $past(q_reg.set))
        else $error("synonym mismatch not refilled in same set");
    // Word layout while the handler owns the bus
    chk_fill_onehot: assert property (tbus_oe && tbus_out[H_FN_HI:H_FN_LO] == FN_FILL
        |-> $onehot(tbus_out[H_WEN_HI:H_WEN_LO])
        && tbus_out[H_DADR_HI:H_DADR_LO+3] == q_reg.paddr[21:7])
        else $error("fill enables or address wrong");
    chk_inval_synonym: assert property (tbus_out[H_FN_HI:H_FN_LO] == FN_INVAL
        |-> tbus_out[3:0] == q_reg.syn && tbus_out[39:16] == q_reg.paddr[39:16])
        else $error("invalidate word lacks synonym or tag");
    // Only 68 bits belong to the handler; its reserved bits stay low
    chk_reserved_low: assert property (tbus_oe |-> tbus_out[71:68] == 4'h0 && !tbus_out[4])
        else $error("reserved handler bits driven high");
    // Tag address and set stay on the line being handled throughout
    chk_tag_field_held: assert property (tbus_oe
        |-> tbus_out[H_TADR_HI:H_TADR_LO] == q_reg.paddr[39:5] && tbus_out[H_DSET_HI:H_DSET_LO] == tag_set)
        else $error("tag address or set field wrong");
    // Release ordering
    chk_release_quiet: assert property (bus_release |-> !tbus_oe && !tag_we)
        else $error("bus released while still driving");
    chk_release_timing: assert property ($rose(bus_release)
        |-> $past(tbus_out[H_FN_HI:H_FN_LO]) == FN_DRAIN || $past(tbus_out[H_WEN_HI:H_WEN_LO]) == 4'h8)
        else $error("release before last fill word");

endmodule

// ### mth_pkg.sv
// Shared constants for the miss handler: transfer bus layout, function codes,
// tag bus layout, software register map and reset values.
package mth_pkg;

    // Transfer bus width between processor and miss handler
    localparam int TB_W = 72;
    localparam int TAG_W = 20;

    // Processor-driven word layout
    localparam int P_CMD_HI = 59;
    localparam int P_CMD_LO = 56;
    localparam int P_SIZE_HI = 55;
    localparam int P_SIZE_LO = 53;
    localparam int P_COH_HI = 52;
    localparam int P_COH_LO = 50;
    localparam int P_NM_TAG = 49; // High: tag address did not match
    localparam int P_NM_SYN = 48; // High: virtual synonym did not match
    localparam int P_SET_HI = 47;
    localparam int P_SET_LO = 46;
    localparam int P_ST_HI = 45;
    localparam int P_ST_LO = 44;
    localparam int P_SYN_HI = 43;
    localparam int P_SYN_LO = 40;
    localparam int P_PA_HI = 39;
    localparam int P_PA_LO = 0;

    // Miss-handler-driven word layout
    localparam int H_FN_HI = 67;
    localparam int H_FN_LO = 64;
    localparam int H_WEN_HI = 63;
    localparam int H_WEN_LO = 60;
    localparam int H_DSET_HI = 59;
    localparam int H_DSET_LO = 58;
    localparam int H_DADR_HI = 57;
    localparam int H_DADR_LO = 40;
    localparam int H_TADR_HI = 39;
    localparam int H_TADR_LO = 5;
    localparam int H_VSYN_HI = 3;
    localparam int H_VSYN_LO = 0;

    // Function codes driven on the handler word
    localparam logic [3:0] FN_IDLE = 4'h0;
    localparam logic [3:0] FN_INVAL = 4'h1;
    localparam logic [3:0] FN_TAG_WR = 4'h2;
    localparam logic [3:0] FN_TAG_ST = 4'h3;
    localparam logic [3:0] FN_FILL = 4'h4;
    localparam logic [3:0] FN_DRAIN = 4'h5;

    // One sector is 128 bytes, written as 32 words of 4 bytes
    localparam logic [4:0] SECTOR_LAST = 5'h1f;
    localparam logic [3:0] WEN_ONE = 4'h1;

    // Software register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_REQ = 8'h08;
    localparam logic [7:0] ADDR_PA_LO = 8'h0c;
    localparam logic [7:0] ADDR_PA_HI = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;

    // Control bits and reset value
    localparam int CTRL_EN = 0;
    localparam int CTRL_DRAIN = 1;
    localparam logic [1:0] CTRL_RST = 2'h1;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Handler sequence
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DECODE,
        ST_INVAL,
        ST_TAGWR,
        ST_STWR,
        ST_FILL,
        ST_DRAIN,
        ST_RELEASE
    } mth_state_t;

endpackage

// ### mth_cpu_model.sv
`timescale 1ns/1ps
// Processor side of the transfer bus: issues miss requests and watches the handler's words
module mth_cpu_model
    import mth_pkg::*;
(
    input wire logic aclk,
    input wire logic [TB_W-1:0] tbus_out,
    input wire logic tbus_oe,
    input wire logic bus_release,
    output logic miss_req,
    output logic [TB_W-1:0] tbus_in
);
    logic driving = 1'b0; // Request word is on the bus
    logic clr = 1'b0; // Start of a request: the monitor clears its tallies
    logic [TB_W-1:0] word = '0; // Word held for the whole miss
    logic [7:0] n_inval, n_fill, n_drain, n_bad; // Tallies of one request
    logic [3:0] inv_syn, last_fn;
    logic [34:0] inv_tadr;
    logic [1:0] fill_set;

    initial begin
        miss_req = 1'b0;
        tbus_in = 72'h55_5555_5555_5555_5555;
    end

    // Outside a miss the bus carries floating point traffic, so the pattern toggles every cycle
    // The processor has no tag RAM outputs here: it only looks up, the handler writes
    always @(posedge aclk) begin
        miss_req <= driving;
        tbus_in <= driving ? word : ~tbus_in; // Stable 72-bit word during the miss
    end

    // Only the function field changes processor state
    always @(posedge aclk) begin
        if (clr) begin
            // Tallies are written by this process alone
            {n_inval, n_fill, n_drain, n_bad} <= '0;
            last_fn <= FN_IDLE;
        end else if (tbus_oe === 1'b1) begin
            last_fn <= tbus_out[H_FN_HI:H_FN_LO];
            // Reserved bits 71:68 set, or words still driven after release, count as faults
            if (tbus_out[71:68] !== 4'h0 || bus_release !== 1'b0) n_bad <= n_bad + 1;
            case (tbus_out[H_FN_HI:H_FN_LO])
                FN_INVAL: begin // Index from 15:5, synonym 3:0 joined to tag 39:16
                    n_inval <= n_inval + 1;
                    inv_syn <= tbus_out[H_VSYN_HI:H_VSYN_LO];
                    inv_tadr <= tbus_out[H_TADR_HI:H_TADR_LO];
                    if (n_fill != 0) n_bad <= n_bad + 1;
                end
                FN_FILL: begin // Word n must carry address {pa[21:7], n[4:2]} and one-hot enable n[1:0]
                    n_fill <= n_fill + 1;
                    fill_set <= tbus_out[H_DSET_HI:H_DSET_LO];
                    if (tbus_out[H_DADR_HI:H_DADR_LO] !== {word[21:7], n_fill[4:2]} ||
                        tbus_out[H_WEN_HI:H_WEN_LO] !== (WEN_ONE << n_fill[1:0])) n_bad <= n_bad + 1;
                end
                FN_DRAIN: n_drain <= n_drain + 1;
                default: ;
            endcase
        end
    end

    // One miss: f is {cmd, size, coh, no-match, set, state, synonym}, reserved top bits zero
    task automatic request(input logic [19:0] f, input logic [39:0] pa, input int lim, output logic ok);
        int w;
        @(posedge aclk);
        clr <= 1'b1;
        word <= {12'h000, f, pa};
        driving <= 1'b1;
        @(posedge aclk);
        clr <= 1'b0;
        w = 0;
        while (bus_release !== 1'b1 && w < lim) begin
            @(posedge aclk);
            w++;
        end
        ok = (w < lim);
        driving <= 1'b0;
        while (bus_release !== 1'b0) @(posedge aclk);
    endtask
endmodule

// ### mth_miss_handler_bench.sv
`timescale 1ns/1ps
// Bench: software side over AXI4-Lite, processor side through the model
module mth_miss_handler_bench;
    import mth_pkg::*;
    logic aclk, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic miss_req, tbus_oe, bus_release, tag_bus_oe, tag_we, tag_sel_state;
    logic [TB_W-1:0] tbus_in, tbus_out;
    logic [TAG_W-1:0] tag_bus_out;
    logic [1:0] tag_set;
    logic [23:0] tg [0:3]; // {oe, sel, set, bus} of each tag cycle
    int tn = 0, cyc = 0, fails = 0, samples_checked = 0;

    mth_miss_handler i_mth_miss_handler (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .miss_req(miss_req), .tbus_in(tbus_in),
        .tbus_out(tbus_out), .tbus_oe(tbus_oe), .bus_release(bus_release), .tag_bus_out(tag_bus_out),
        .tag_bus_oe(tag_bus_oe), .tag_we(tag_we), .tag_sel_state(tag_sel_state), .tag_set(tag_set));
    mth_cpu_model i_mth_cpu_model (.aclk(aclk), .tbus_out(tbus_out), .tbus_oe(tbus_oe),
        .bus_release(bus_release), .miss_req(miss_req), .tbus_in(tbus_in));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Record the first tag RAM cycles of a request in order
    always @(posedge aclk) begin
        if (i_mth_cpu_model.clr === 1'b1) begin
            tn <= 0;
        end else if (tag_we === 1'b1 && tn < 4) begin
            tg[tn] <= {tag_bus_oe, tag_sel_state, tag_set, tag_bus_out};
            tn <= tn + 1;
        end
    end

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run;
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Address and data offered together, each dropped on its own handshake
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_p, w_p;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
        {aw_p, w_p} = 2'b11;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && s_axi_awready === 1'b1) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready === 1'b1) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // Read one word and compare data and response
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        check(s_axi_rdata, exp_d);
        check(s_axi_rresp, exp_r);
        s_axi_rready <= 1'b0;
    endtask

    initial begin
        logic [19:0] f;
        logic [39:0] pa;
        logic [1:0] k, exp_set, r;
        logic ok, miss;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
        rd_chk(ADDR_COUNT, 32'h0000_0000, RESP_OKAY);
        rd_chk(8'h3c, 32'h0000_0000, RESP_SLVERR);
        axi_wr(8'h3c, 32'hffff_ffff, r);
        check(r, RESP_SLVERR);
        // Every no-match code: full hit, synonym mismatch, two tag misses
        for (int i = 0; i < 4; i++) begin
            k = 2'(i);
            f = {4'h3 + {2'b00, k}, 3'h1 + {1'b0, k}, ~{1'b0, k}, k, ~k, 2'(i % 3), 4'ha ^ {2'b00, k}};
            pa = 40'h9a_1234_5680 + 40'(i) * 40'h00_0010_1080;
            i_mth_cpu_model.request(f, pa, 400, ok);
            miss = (k != 2'b00);
            // Round-robin victim starts at set 0 after reset: first tag miss set 0, second set 1
            exp_set = k[1] ? {1'b0, k[0]} : f[7:6];
            check(ok, 1'b1);
            check(i_mth_cpu_model.n_inval, {7'h00, miss});
            check(i_mth_cpu_model.n_fill, 8'h20);
            check(i_mth_cpu_model.n_bad, 8'h00);
            check(i_mth_cpu_model.fill_set, exp_set);
            check(i_mth_cpu_model.last_fn, FN_FILL);
            check(tn, miss ? 2 : 0);
            if (miss) begin
                check(i_mth_cpu_model.inv_syn, f[3:0]);
                check(i_mth_cpu_model.inv_tadr, pa[39:5]);
                check(tg[0], {2'b10, exp_set, pa[39:20]});
                check(tg[1], {2'b11, exp_set, 14'h0000, f[5:0]});
            end
            rd_chk(ADDR_REQ, {12'h000, f}, RESP_OKAY);
            rd_chk(ADDR_PA_LO, pa[31:0], RESP_OKAY);
            rd_chk(ADDR_PA_HI, {24'h00_0000, pa[39:32]}, RESP_OKAY);
            rd_chk(ADDR_COUNT, 32'(i + 1), RESP_OKAY);
        end
        // Idle, last fill in set 1, next victim set 2
        rd_chk(ADDR_STATUS, 32'h0000_0048, RESP_OKAY);
        // Drain word before the bus goes back
        axi_wr(ADDR_CTRL, 32'h0000_0003, r);
        i_mth_cpu_model.request(20'h1_0080, 40'h00_0000_0100, 400, ok);
        check(i_mth_cpu_model.n_drain, 8'h01);
        check(i_mth_cpu_model.last_fn, FN_DRAIN);
        // A write while no miss is being taken clears the miss count
        axi_wr(ADDR_COUNT, 32'h0000_0000, r);
        rd_chk(ADDR_COUNT, 32'h0000_0000, RESP_OKAY);
        // Disabled handler leaves the bus to the processor
        axi_wr(ADDR_CTRL, 32'h0000_0000, r);
        i_mth_cpu_model.request(20'h1_0080, 40'h00_0000_0100, 40, ok);
        check(ok, 1'b0);
        check(i_mth_cpu_model.n_fill, 8'h00);
        // Second reset restores the enable
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
        complete_run();
    end
endmodule
